// ===== pkg/dmi_dec_if.sv
/*
 * Carrier between the interlock and its instruction decoder.
 * Assumes the decoder is purely combinational.
 */
`timescale 1ns/1ps
interface dmi_dec_if;
    import dmi_pkg::*;

    logic [31:0] word;
    dmi_cls_t    cls;
    logic        is_32;
    logic        x_idle;
    logic        y_idle;
    logic        single_move;
    logic        add_idle;
    logic        quiet_shift;

    modport dec (input word, output cls, is_32, x_idle, y_idle,
                 single_move, add_idle, quiet_shift);
    modport use_side (output word, input cls, is_32, x_idle, y_idle,
                      single_move, add_idle, quiet_shift);
endinterface

// ===== pkg/dmi_pkg.sv
/*
 * Shared constants for the DSP/multiplier issue interlock: instruction
 * classes, opcode masks and matches, multiplier occupancy and the
 * saturation bit position.
 * Assumes a 16-bit instruction sits in the upper half of a 32-bit word.
 */
package dmi_pkg;

    // ----------------------------------------------------------------
    // Instruction classes
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        DMI_CLS_OTHER    = 3'b000,
        DMI_CLS_DSP_ALU  = 3'b001,
        DMI_CLS_DSP_MUL  = 3'b010,
        DMI_CLS_MOVE     = 3'b011,
        DMI_CLS_LONG_MUL = 3'b100,
        DMI_CLS_WORD_MULTIPLY_ACCUMULATE    = 3'b101,
        DMI_CLS_SR_LOAD  = 3'b110
    } dmi_cls_t;

    // ----------------------------------------------------------------
    // Prefixes (upper halfword)
    // ----------------------------------------------------------------
    localparam logic [5:0]  DSP_PREFIX      = 6'h3e;
    localparam logic [5:0]  MOVE_PREFIX     = 6'h3c;
    localparam logic [5:0]  SINGLE_PREFIX   = 6'h3d;
    localparam logic [15:0] DSP_ADD_IDLE_HI = 16'hf800;
    localparam logic [15:0] XLOAD_IDLE_Y    = 16'hf008;
    localparam logic [15:0] SINGLE_XLOAD    = 16'hf488;
    localparam int          PREFIX_LSB      = 10;
    localparam logic [15:0] X_OP_MASK       = 16'h000c;
    localparam logic [15:0] Y_OP_MASK       = 16'h0003;

    // ----------------------------------------------------------------
    // DSP operation half (lower halfword), mask then match
    // ----------------------------------------------------------------
    localparam logic [15:0] PMUL_MASK  = 16'hf0f3;
    localparam logic [15:0] PMUL_MATCH = 16'h4000;
    localparam logic [15:0] PXFR_MASK  = 16'hccf0;
    localparam logic [15:0] PXFR_MATCH = 16'hcc00;
    localparam logic [15:0] PXFR_NZ    = 16'h0300;
    localparam logic [15:0] PSHI_MASK  = 16'hf800;
    localparam logic [15:0] PSHI_MATCH = 16'h1000;
    localparam int          IMM_LSB    = 4;
    localparam logic [6:0]  QUIET_IMM  = 7'h05;
    localparam logic [3:0]  ACC0_CODE  = 4'h7;

    // ----------------------------------------------------------------
    // Integer multiplier users and status load (16-bit)
    // ----------------------------------------------------------------
    localparam logic [15:0] OP_MASK      = 16'hf00f;
    localparam logic [15:0] MULL_MATCH   = 16'h0007;
    localparam logic [15:0] DMULU_MATCH  = 16'h3005;
    localparam logic [15:0] DMULS_MATCH  = 16'h300d;
    localparam logic [15:0] MACL_MATCH   = 16'h000f;
    localparam logic [15:0] MACW_MATCH   = 16'h400f;
    localparam logic [15:0] LDSR_MASK    = 16'hf0ff;
    localparam logic [15:0] LDSR_MATCH   = 16'h400e;

    // ----------------------------------------------------------------
    // Multiplier occupancy and status register
    // ----------------------------------------------------------------
    localparam logic [3:0]  LONG_MUL_CYCLES = 4'h4;
    localparam logic [3:0]  WORD_MULTIPLY_ACCUMULATE_CYCLES    = 4'h2;
    localparam logic [3:0]  BUSY_NONE       = 4'h0;
    localparam logic [3:0]  BUSY_STEP       = 4'h1;
    localparam int          SAT_BIT         = 1;
    localparam logic        SAT_RESET       = 1'b0;

endpackage

// ===== src/dmi_decode.sv
/*
 * Instruction classifier: resource class and move slot state.
 * Assumes the word arrives on the same clock; no state is held here.
 */
`timescale 1ns/1ps
module dmi_decode (
    dmi_dec_if.dec d
);
    import dmi_pkg::*;

    logic [15:0] hi;
    logic [15:0] lo;

    always_comb begin
        hi = d.word[31:16];
        lo = d.word[15:0];
        d.is_32       = (hi[15:PREFIX_LSB] == DSP_PREFIX);
        // ------------------------------------------------------------
        // Move slots: idle is a field value, so written and omitted
        // idle moves classify alike
        // ------------------------------------------------------------
        d.x_idle      = ((hi & X_OP_MASK) == '0);
        d.y_idle      = ((hi & Y_OP_MASK) == '0);
        d.add_idle    = d.is_32 && (hi == DSP_ADD_IDLE_HI);
        d.single_move = (hi[15:PREFIX_LSB] == SINGLE_PREFIX)
                        || (hi == SINGLE_XLOAD);
        d.quiet_shift = d.is_32 && ((lo & PSHI_MASK) == PSHI_MATCH)
                        && (lo[10:IMM_LSB] == QUIET_IMM)
                        && (lo[3:0] == ACC0_CODE);
        // ------------------------------------------------------------
        // Resource class
        // ------------------------------------------------------------
        if (d.is_32) begin
            if (((lo & PMUL_MASK) == PMUL_MATCH)
                || (((lo & PXFR_MASK) == PXFR_MATCH)
                    && ((lo & PXFR_NZ) != '0))) begin
                d.cls = DMI_CLS_DSP_MUL;
            end else begin
                d.cls = DMI_CLS_DSP_ALU;
            end
        end else if ((hi[15:PREFIX_LSB] == MOVE_PREFIX)
                     || d.single_move || (hi == XLOAD_IDLE_Y)) begin
            d.cls = DMI_CLS_MOVE;
        end else if (((hi & OP_MASK) == MULL_MATCH)
                     || ((hi & OP_MASK) == DMULU_MATCH)
                     || ((hi & OP_MASK) == DMULS_MATCH)
                     || ((hi & OP_MASK) == MACL_MATCH)) begin
            d.cls = DMI_CLS_LONG_MUL;
        end else if ((hi & OP_MASK) == MACW_MATCH) begin
            d.cls = DMI_CLS_WORD_MULTIPLY_ACCUMULATE;
        end else if ((hi & LDSR_MASK) == LDSR_MATCH) begin
            d.cls = DMI_CLS_SR_LOAD;
        end else begin
            d.cls = DMI_CLS_OTHER;
        end
    end
endmodule

// ===== src/dmi_interlock.sv
/*
 * Issue stage interlock for a combined integer/DSP pipeline sharing
 * one multiplier. Holds multiplier users while a multi-cycle multiply
 * runs, lets other instructions pass, and keeps status loads in order.
 * Assumes the fetch stage holds a word stable while ready is low and
 * supplies the status load value alongside the load instruction.
 */
`timescale 1ns/1ps
module dmi_interlock (
    input  wire logic             clock,
    input  wire logic             rst_n,
    input  wire logic             instr_valid,
    input  wire logic [31:0]      instr_word,
    input  wire logic             instr_in_slot,
    input  wire logic             sr_load_sat,
    output logic                  instr_ready,
    output logic                  issue_valid,
    output logic [31:0]           issue_word,
    output dmi_pkg::dmi_cls_t     issue_cls,
    output logic                  issue_x_idle,
    output logic                  issue_y_idle,
    output logic                  issue_single_move,
    output logic                  issue_add_idle,
    output logic                  issue_in_slot,
    output logic                  issue_mac_sat,
    output logic                  mul_sat,
    output logic                  mul_busy,
    output logic                  sat_mode,
    output logic                  dsp_quiet
);
    import dmi_pkg::*;

    // ----------------------------------------------------------------
    // Decoder
    // ----------------------------------------------------------------
    dmi_dec_if dec_bus ();

    assign dec_bus.word = instr_word;

    dmi_decode u_decode (
        .d (dec_bus.dec)
    );

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    logic [3:0]  busy_cnt_reg;
    logic [3:0]  busy_cnt_next;
    logic        mul_sat_reg;
    logic        mul_sat_next;
    logic        sat_reg;
    logic        sat_next;
    logic        quiet_reg;
    logic        quiet_next;
    logic        clr_seen_reg;
    logic        clr_seen_next;
    logic        iv_reg;
    logic        iv_next;
    logic [31:0] iw_reg;
    logic [31:0] iw_next;
    dmi_cls_t    ic_reg;
    dmi_cls_t    ic_next;
    logic        ix_reg;
    logic        ix_next;
    logic        iy_reg;
    logic        iy_next;
    logic        is_reg;
    logic        is_next;
    logic        ia_reg;
    logic        ia_next;
    logic        isl_reg;
    logic        isl_next;
    logic        ims_reg;
    logic        ims_next;

    logic        uses_mul;
    logic        is_mac;
    logic        stall;
    logic        take;
    logic        mul_free;

    // ----------------------------------------------------------------
    // Interlock
    // ----------------------------------------------------------------
    always_comb begin
        mul_free = (busy_cnt_reg == BUSY_NONE);
        uses_mul = (dec_bus.cls == DMI_CLS_DSP_MUL)
                   || (dec_bus.cls == DMI_CLS_LONG_MUL)
                   || (dec_bus.cls == DMI_CLS_WORD_MULTIPLY_ACCUMULATE);
        is_mac   = (dec_bus.cls == DMI_CLS_WORD_MULTIPLY_ACCUMULATE)
                   || ((dec_bus.cls == DMI_CLS_LONG_MUL)
                       && ((instr_word[31:16] & OP_MASK) == MACL_MATCH));
        // Only valid, class and busy count matter: branch slot position
        // and fetch source never enter the stall term
        stall    = instr_valid && uses_mul && !mul_free;
        // In-order issue: a status load behind a stalled accumulate
        // waits with it, so it cannot overtake
        instr_ready = !stall;
        take     = instr_valid && !stall;
    end

    // ----------------------------------------------------------------
    // Multiplier occupancy and saturation
    // ----------------------------------------------------------------
    always_comb begin
        busy_cnt_next = busy_cnt_reg;
        mul_sat_next  = mul_sat_reg;
        sat_next      = sat_reg;
        if (!mul_free) begin
            busy_cnt_next = busy_cnt_reg - BUSY_STEP;
        end
        if (take && (dec_bus.cls == DMI_CLS_LONG_MUL)) begin
            busy_cnt_next = LONG_MUL_CYCLES;
        end else if (take && (dec_bus.cls == DMI_CLS_WORD_MULTIPLY_ACCUMULATE)) begin
            busy_cnt_next = WORD_MULTIPLY_ACCUMULATE_CYCLES;
        end
        if (take && is_mac) begin
            // Mode captured at issue, so a later status load cannot
            // reach an accumulate already in the multiplier
            mul_sat_next = sat_reg;
        end
        if (take && (dec_bus.cls == DMI_CLS_SR_LOAD)) begin
            sat_next = sr_load_sat;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            busy_cnt_reg <= BUSY_NONE;
            mul_sat_reg  <= SAT_RESET;
            sat_reg      <= SAT_RESET;
        end else begin
            busy_cnt_reg <= busy_cnt_next;
            mul_sat_reg  <= mul_sat_next;
            sat_reg      <= sat_next;
        end
    end

    // ----------------------------------------------------------------
    // Quiet idiom tracker
    // ----------------------------------------------------------------
    always_comb begin
        clr_seen_next = clr_seen_reg;
        quiet_next    = quiet_reg;
        if (take && dec_bus.is_32) begin
            // Accumulator clear is any non-multiplier DSP op but a quiet shift ahead of
            // the shift; a cheap match, traded for exactness
            quiet_next    = dec_bus.quiet_shift && clr_seen_reg;
            clr_seen_next = (dec_bus.cls == DMI_CLS_DSP_ALU)
                            && !dec_bus.quiet_shift;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            clr_seen_reg <= 1'b0;
            quiet_reg    <= 1'b0;
        end else begin
            clr_seen_reg <= clr_seen_next;
            quiet_reg    <= quiet_next;
        end
    end

    // ----------------------------------------------------------------
    // Issue register
    // ----------------------------------------------------------------
    always_comb begin
        iv_next  = take;
        iw_next  = iw_reg;
        ic_next  = ic_reg;
        ix_next  = ix_reg;
        iy_next  = iy_reg;
        is_next  = is_reg;
        ia_next  = ia_reg;
        isl_next = isl_reg;
        ims_next = ims_reg;
        // Loaded only on issue: a bypassing op is never touched by the
        // hold of a stalled multiplier user
        if (take) begin
            iw_next  = instr_word;
            ic_next  = dec_bus.cls;
            ix_next  = dec_bus.x_idle;
            iy_next  = dec_bus.y_idle;
            is_next  = dec_bus.single_move;
            ia_next  = dec_bus.add_idle;
            isl_next = instr_in_slot;
            ims_next = is_mac ? sat_reg : ims_reg;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            iv_reg  <= 1'b0;
            iw_reg  <= '0;
            ic_reg  <= DMI_CLS_OTHER;
            ix_reg  <= 1'b0;
            iy_reg  <= 1'b0;
            is_reg  <= 1'b0;
            ia_reg  <= 1'b0;
            isl_reg <= 1'b0;
            ims_reg <= SAT_RESET;
        end else begin
            iv_reg  <= iv_next;
            iw_reg  <= iw_next;
            ic_reg  <= ic_next;
            ix_reg  <= ix_next;
            iy_reg  <= iy_next;
            is_reg  <= is_next;
            ia_reg  <= ia_next;
            isl_reg <= isl_next;
            ims_reg <= ims_next;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign issue_valid       = iv_reg;
    assign issue_word        = iw_reg;
    assign issue_cls         = ic_reg;
    assign issue_x_idle      = ix_reg;
    assign issue_y_idle      = iy_reg;
    assign issue_single_move = is_reg;
    assign issue_add_idle    = ia_reg;
    assign issue_in_slot     = isl_reg;
    assign issue_mac_sat     = ims_reg;
    assign mul_sat           = mul_sat_reg;
    assign mul_busy          = !mul_free;
    assign sat_mode          = sat_reg;
    assign dsp_quiet         = quiet_reg;

endmodule

// ===== test/dmi_fetch_model.sv
/*
 * Fetch stage model: offers one word at a time on the falling edge.
 * Assumes the bench calls offer and release_bus in sequence.
 */
`timescale 1ns/1ps
module dmi_fetch_model (
    input  wire logic  clock,
    input  wire logic  instr_ready,
    output logic       instr_valid,
    output logic [31:0] instr_word,
    output logic       instr_in_slot,
    output logic       sr_load_sat
);
    initial begin
        instr_valid = 1'b0;
        instr_word = 32'h0;
        instr_in_slot = 1'b0;
        sr_load_sat = 1'b0;
    end

    task automatic offer(input logic [31:0] w, input logic sl,
                         input logic s, output int waits);
        waits = 0;
        @(negedge clock);
        instr_valid = 1'b1;
        instr_word = w;
        instr_in_slot = sl;
        sr_load_sat = s;
        #1;
        // Word held untouched while refused
        while (instr_ready !== 1'b1) begin
            waits++;
            @(negedge clock);
            #1;
        end
        @(posedge clock);
    endtask

    // Released lines flip so a stale value cannot pass for fresh data
    task automatic release_bus();
        @(negedge clock);
        instr_valid = 1'b0;
        instr_word = ~instr_word;
        instr_in_slot = ~instr_in_slot;
        sr_load_sat = ~sr_load_sat;
    endtask
endmodule

// ===== test/dmi_interlock_props.sv
/*
 * Concurrent checks on the interlock top-level ports.
 * Assumes one clock domain and a synchronous active-low reset.
 */
`timescale 1ns/1ps
module dmi_interlock_props
    import dmi_pkg::*;
(
    input wire logic        clock,
    input wire logic        rst_n,
    input wire logic        instr_valid,
    input wire logic [31:0] instr_word,
    input wire logic        instr_in_slot,
    input wire logic        sr_load_sat,
    input wire logic        instr_ready,
    input wire logic        issue_valid,
    input wire logic [31:0] issue_word,
    input dmi_pkg::dmi_cls_t issue_cls,
    input wire logic        issue_single_move,
    input wire logic        issue_add_idle,
    input wire logic        issue_in_slot,
    input wire logic        issue_mac_sat,
    input wire logic        mul_busy,
    input wire logic        sat_mode
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    // ----------------------------------------------------------------
    // Sequences
    // ----------------------------------------------------------------
    sequence s_take;      instr_valid && instr_ready;          endsequence
    sequence s_long_hold; mul_busy [*4] ##1 !mul_busy;         endsequence
    sequence s_macw_hold; mul_busy [*2] ##1 !mul_busy;         endsequence

    property p_stall_cause;
        !instr_ready |-> instr_valid && mul_busy;
    endproperty
    a_stall_cause: assert property (p_stall_cause) else $error("stall without busy multiplier");
    property p_alu_bypass;
        instr_valid && instr_word[31:26] == DSP_PREFIX
            && (instr_word[15:8] == 8'hb1
                || (instr_word[15:0] & PSHI_MASK) == PSHI_MATCH)
            |-> instr_ready;
    endproperty
    a_alu_bypass: assert property (p_alu_bypass) else $error("dsp alu op stalled");
    property p_issue;
        s_take |=> issue_valid && issue_word == $past(instr_word);
    endproperty
    a_issue: assert property (p_issue) else $error("taken word not issued");
    property p_no_issue;
        !(instr_valid && instr_ready) |=> !issue_valid;
    endproperty
    a_no_issue: assert property (p_no_issue) else $error("issue without take");
    property p_long_busy;
        issue_valid && issue_cls == DMI_CLS_LONG_MUL |-> s_long_hold;
    endproperty
    a_long_busy: assert property (p_long_busy) else $error("long multiply occupancy wrong");
    property p_macw_busy;
        issue_valid && issue_cls == DMI_CLS_WORD_MULTIPLY_ACCUMULATE |-> s_macw_hold;
    endproperty
    a_macw_busy: assert property (p_macw_busy) else $error("word accumulate occupancy wrong");
    property p_sat_load;
        issue_valid && issue_cls == DMI_CLS_SR_LOAD
            |-> sat_mode == $past(sr_load_sat);
    endproperty
    a_sat_load: assert property (p_sat_load) else $error("status load value lost");
    property p_sat_hold;
        !(issue_valid && issue_cls == DMI_CLS_SR_LOAD) |-> $stable(sat_mode);
    endproperty
    a_sat_hold: assert property (p_sat_hold) else $error("saturation changed out of order");
    property p_mac_sat;
        issue_valid && issue_cls == DMI_CLS_WORD_MULTIPLY_ACCUMULATE |-> issue_mac_sat == sat_mode;
    endproperty
    a_mac_sat: assert property (p_mac_sat) else $error("accumulate saturation mode wrong");
    property p_add_idle;
        issue_valid |-> issue_add_idle == (issue_word[31:16] == DSP_ADD_IDLE_HI);
    endproperty
    a_add_idle: assert property (p_add_idle) else $error("idle add flag wrong");
    property p_single;
        issue_valid
            |-> issue_single_move == (issue_word[31:26] == SINGLE_PREFIX);
    endproperty
    a_single: assert property (p_single) else $error("single move flag wrong");
    property p_slot;
        s_take |=> issue_in_slot == $past(instr_in_slot);
    endproperty
    a_slot: assert property (p_slot) else $error("slot flag not carried");
endmodule

bind dmi_interlock dmi_interlock_props u_props (
    .clock(clock), .rst_n(rst_n), .instr_valid(instr_valid),
    .instr_word(instr_word), .instr_in_slot(instr_in_slot),
    .sr_load_sat(sr_load_sat), .instr_ready(instr_ready),
    .issue_valid(issue_valid), .issue_word(issue_word),
    .issue_cls(issue_cls), .issue_single_move(issue_single_move),
    .issue_add_idle(issue_add_idle), .issue_in_slot(issue_in_slot),
    .issue_mac_sat(issue_mac_sat), .mul_busy(mul_busy),
    .sat_mode(sat_mode)
);

// ===== test/test_dmi_interlock.sv
/*
 * Self-checking bench for the interlock: queued expectations, a
 * monitor on issue, stall counts measured by the fetch model.
 * Assumes the fetch model and checker files are compiled first.
 */
`timescale 1ns/1ps
module test_dmi_interlock;
    import dmi_pkg::*;
    typedef struct packed {
        logic [31:0] w; dmi_cls_t c; logic sl; logic ck; logic s;
    } dmi_exp_t;
    localparam logic [31:0] W_MULL = 32'h01270000, W_DMULU = 32'h31250000;
    localparam logic [31:0] W_DMULS = 32'h312d0000, W_MACL = 32'h012f0000;
    localparam logic [31:0] W_MACW = 32'h412f0000, W_SR = 32'h410e0000;
    localparam logic [31:0] W_MOVE_FROM_MULTIPLY_RESULT = 32'hf800cd00, W_MOVE_TO_MULTIPLY_RESULT = 32'hf800ed00;
    localparam logic [31:0] W_QUIET = 32'hf8001057;
    logic clock = 1'b0, rst_n = 1'b0;
    logic instr_valid, instr_in_slot, sr_load_sat, instr_ready, issue_valid;
    logic issue_x_idle, issue_y_idle, issue_single_move, issue_add_idle;
    logic issue_in_slot, issue_mac_sat, mul_sat, mul_busy, sat_mode, dsp_quiet;
    logic [31:0] instr_word, issue_word;
    dmi_cls_t issue_cls;
    logic sat_exp = 1'b0;
    int mismatches = 0, n_checks = 0;
    dmi_exp_t exp_q[$];

    always #2 clock = ~clock;

    dmi_interlock dut (.clock(clock), .rst_n(rst_n),
        .instr_valid(instr_valid), .instr_word(instr_word),
        .instr_in_slot(instr_in_slot), .sr_load_sat(sr_load_sat),
        .instr_ready(instr_ready), .issue_valid(issue_valid),
        .issue_word(issue_word), .issue_cls(issue_cls),
        .issue_x_idle(issue_x_idle), .issue_y_idle(issue_y_idle),
        .issue_single_move(issue_single_move),
        .issue_add_idle(issue_add_idle), .issue_in_slot(issue_in_slot),
        .issue_mac_sat(issue_mac_sat), .mul_sat(mul_sat),
        .mul_busy(mul_busy), .sat_mode(sat_mode), .dsp_quiet(dsp_quiet));
    dmi_fetch_model fetch (.clock(clock), .instr_ready(instr_ready),
        .instr_valid(instr_valid), .instr_word(instr_word),
        .instr_in_slot(instr_in_slot), .sr_load_sat(sr_load_sat));

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    task automatic check(input string n, input logic [31:0] e,
                         input logic [31:0] s);
        n_checks++;
        if (s !== e) begin
            $display("ERROR %s expected %h seen %h", n, e, s);
            mismatches++;
        end
    endtask

    function automatic logic [31:0] w_add();
        return {16'hf800, 8'hb1, 8'($urandom)};
    endfunction
    function automatic logic [31:0] w_long(input int k);
        return k == 0 ? W_MULL : k == 1 ? W_DMULU : k == 2 ? W_DMULS : W_MACL;
    endfunction
    function automatic logic [31:0] w_user(input int k);
        logic [15:0] r;
        r = 16'($urandom) & 16'h0f0c;
        return k % 3 == 0 ? {16'hf800, 16'h4000 | r} : k % 3 == 1 ? W_MOVE_FROM_MULTIPLY_RESULT : W_MOVE_TO_MULTIPLY_RESULT;
    endfunction

    task automatic send(input logic [31:0] w, input dmi_cls_t c,
                        input int ew, input logic s = 1'b0,
                        input logic sl = 1'b0);
        int wt;
        logic ck;
        ck = (c == DMI_CLS_WORD_MULTIPLY_ACCUMULATE) || (w == W_MACL);
        exp_q.push_back('{w, c, sl, ck, sat_exp});
        if (c == DMI_CLS_SR_LOAD) sat_exp = s;
        fetch.offer(w, sl, s, wt);
        check("stall cycles", ew, wt);
    endtask

    // ----------------------------------------------------------------
    // Monitor: oldest note against each issued word
    // ----------------------------------------------------------------
    always @(negedge clock) begin
        dmi_exp_t e;
        if (rst_n === 1'b1 && issue_valid === 1'b1) begin
            if (exp_q.size() == 0) check("unexpected issue", 0, 1);
            else begin
                e = exp_q.pop_front();
                check("issue_word", e.w, issue_word);
                check("issue_cls", e.c, issue_cls);
                check("issue_in_slot", e.sl, issue_in_slot);
                check("issue_add_idle", e.w[31:16] == DSP_ADD_IDLE_HI, issue_add_idle);
                check("issue_single_move", e.w[31:26] == SINGLE_PREFIX, issue_single_move);
                if (e.w[31:16] == DSP_ADD_IDLE_HI || e.w[31:16] == 16'hf000) begin
                    check("issue_x_idle", 1, issue_x_idle);
                    check("issue_y_idle", 1, issue_y_idle);
                end
                if (e.w[31:16] == XLOAD_IDLE_Y) begin
                    check("issue_x_idle", 0, issue_x_idle);
                    check("issue_y_idle", 1, issue_y_idle);
                end
                if (e.ck) check("issue_mac_sat", e.s, issue_mac_sat);
                if (e.ck) check("mul_sat", e.s, mul_sat);
            end
        end
    end

    initial begin
        #40000;
        mismatches++;
        report_and_stop();
    end

    initial begin
        void'($urandom(32'h60e3bd09));
        repeat (10) @(negedge clock);
        rst_n = 1'b1;
        check("instr_ready", 1, instr_ready);
        check("mul_busy", 0, mul_busy);
        check("sat_mode", SAT_RESET, sat_mode);
        check("dsp_quiet", 0, dsp_quiet);
        send(w_add(), DMI_CLS_DSP_ALU, 0);
        send({XLOAD_IDLE_Y, 16'h0000}, DMI_CLS_MOVE, 0);
        send({SINGLE_XLOAD, 16'h0000}, DMI_CLS_MOVE, 0);
        send(32'hf0000000, DMI_CLS_MOVE, 0);
        send(32'h00090000, DMI_CLS_OTHER, 0);
        for (int i = 0; i < 4; i++) begin
            send(w_long(i), DMI_CLS_LONG_MUL, 0);
            send(w_user(i), DMI_CLS_DSP_MUL, 4);
        end
        for (int i = 0; i < 2; i++) begin
            send(w_long(i + 1), DMI_CLS_LONG_MUL, 0, 1'b0, i[0]);
            send(w_add(), DMI_CLS_DSP_ALU, 0);
            send(w_user(i + 1), DMI_CLS_DSP_MUL, 3);
        end
        send(W_MACW, DMI_CLS_WORD_MULTIPLY_ACCUMULATE, 0);
        send(W_MACW, DMI_CLS_WORD_MULTIPLY_ACCUMULATE, 2);
        send(W_MACL, DMI_CLS_LONG_MUL, 2);
        send(W_MACW, DMI_CLS_WORD_MULTIPLY_ACCUMULATE, 4);
        send(W_DMULU, DMI_CLS_LONG_MUL, 2);
        send(W_MACL, DMI_CLS_LONG_MUL, 4);
        send(W_SR, DMI_CLS_SR_LOAD, 0, 1'b1);
        send(W_MACW, DMI_CLS_WORD_MULTIPLY_ACCUMULATE, 3);
        send(w_add(), DMI_CLS_DSP_ALU, 0);
        send(W_SR, DMI_CLS_SR_LOAD, 0, 1'($urandom));
        send(w_add(), DMI_CLS_DSP_ALU, 0);
        send(W_QUIET, DMI_CLS_DSP_ALU, 0);
        fetch.release_bus();
        repeat (3) @(negedge clock);
        check("dsp_quiet", 1, dsp_quiet);
        check("sat_mode", sat_exp, sat_mode);
        check("pending issues", 0, exp_q.size());
        // Second reset in mid-run clears the saturation state
        rst_n = 1'b0;
        repeat (2) @(negedge clock);
        rst_n = 1'b1;
        sat_exp = SAT_RESET;
        check("sat_mode", SAT_RESET, sat_mode);
        check("dsp_quiet", 0, dsp_quiet);
        check("mul_busy", 0, mul_busy);
        send(W_MACW, DMI_CLS_WORD_MULTIPLY_ACCUMULATE, 0);
        fetch.release_bus();
        repeat (4) @(negedge clock);
        check("pending issues", 0, exp_q.size());
        report_and_stop();
    end
endmodule
